// >>> rtl/sram_host_pkg.sv
package sram_host_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_COUNT = 262144;

  // ---------------------------------------------------------------------------
  // Timing in picoseconds (power-up wait in nanoseconds) for the fastest grade, and cycle counts
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int READ_CYCLE_TIME_PS = 10000;
  localparam int ADDRESS_TO_DATA_TIME_PS = 10000;
  localparam int OE_TO_DATA_TIME_PS = 5000;
  localparam int SELECT_TO_DATA_TIME_PS = 10000;
  localparam int LANE_ENABLE_TO_DATA_TIME_PS = 5000;
  localparam int DATA_HOLD_AFTER_ADDRESS_PS = 3000;
  localparam int SELECT_TO_WRITE_END_PS = 7000;
  localparam int ADDRESS_SETUP_TO_WRITE_END_PS = 7000;
  localparam int DESELECT_TO_STANDBY_TIME_PS = 10000;
  localparam int POWER_UP_WAIT_NS = 1000;

  // Least times round up; none below one cycle.
  function automatic int cycles_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Two synchroniser stages sit on the read path before data is captured.
  localparam int SYNC_STAGES = 2;
  localparam int READ_ACCESS_PS = (ADDRESS_TO_DATA_TIME_PS > SELECT_TO_DATA_TIME_PS) ?
      ADDRESS_TO_DATA_TIME_PS : SELECT_TO_DATA_TIME_PS;
  localparam int READ_WAIT_CYC = cycles_up(READ_ACCESS_PS);
  localparam int READ_CYCLE_CYC = cycles_up(READ_CYCLE_TIME_PS);
  localparam int WRITE_PULSE_CYC = cycles_up((SELECT_TO_WRITE_END_PS >
      ADDRESS_SETUP_TO_WRITE_END_PS) ? SELECT_TO_WRITE_END_PS : ADDRESS_SETUP_TO_WRITE_END_PS);
  localparam int POWER_UP_CYC = cycles_up(POWER_UP_WAIT_NS * 1000);
  localparam int CNT_W = 8;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] word_address;
    logic [1:0] lane_keep_n;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic lower_byte_lane_en_n;
    logic upper_byte_lane_en_n;
    logic [ADDR_W-1:0] word_address;
  } sram_pins_t;

  localparam sram_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}};

endpackage

// >>> rtl/sram_host_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sram_host_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;

  // The first stage is read by the second stage only.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/sram_host_ctrl.sv
// Function
// - Write only while select and strobe low.
// - Read: select, output enable low, strobe high.
// - Wait one microsecond before first access.
// - Space reads; wait address-to-data time.
// - Select and address 7 ns before write end.
// - First rising strobe or select ends write.
`timescale 1ns/1ps
`default_nettype none

module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire sram_host_pkg::sram_req_t req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [sram_host_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic [sram_host_pkg::ADDR_W-1:0] word_address_o,
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic output_enable_n_o,
  output logic lower_byte_lane_en_n_o,
  output logic upper_byte_lane_en_n_o,
  output logic [sram_host_pkg::DATA_W-1:0] shared_data_bus_o,
  output logic [sram_host_pkg::DATA_W-1:0] shared_data_bus_oe_n_o,
  input wire logic [sram_host_pkg::DATA_W-1:0] shared_data_bus_i
);

  import sram_host_pkg::*;

  // ---------------------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_POWER = 7'b0000001,
    ST_IDLE  = 7'b0000010,
    ST_WSET  = 7'b0000100,
    ST_WPULS = 7'b0001000,
    ST_WEND  = 7'b0010000,
    ST_RWAIT = 7'b0100000,
    ST_RCAP  = 7'b1000000
  } state_t;

  localparam logic [CNT_W-1:0] READ_WAIT_N = CNT_W'(READ_WAIT_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] WPULSE_N = CNT_W'(WRITE_PULSE_CYC);
  localparam int PWR_W = $clog2(POWER_UP_CYCLES + 1);

  state_t state_r;
  state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [PWR_W-1:0] pwr_cnt_r;
  sram_req_t req_r;
  sram_pins_t pins_r;
  sram_pins_t pins_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [DATA_W-1:0] rd_sync;

  // Lane enables collapse to a single flag for the undriven-lane case.
  function automatic logic lanes_off(input logic [1:0] keep_n);
    return &keep_n;
  endfunction

  wire cnt_done = (cnt_r == '0);
  wire pwr_done = (pwr_cnt_r == '0);
  wire take_req = (state_r == ST_IDLE) && req_valid_i;

  // ---------------------------------------------------------------------------
  // Read-data synchroniser
  // ---------------------------------------------------------------------------
  // The bus is asynchronous to us, so data passes two flops before capture.
  sram_host_sync #(
    .WIDTH(DATA_W)
  ) u_rd_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(shared_data_bus_i),
    .sync_o(rd_sync)
  );

  // ---------------------------------------------------------------------------
  // Next-state and pin decode
  // ---------------------------------------------------------------------------
  // Pins change on state entry, and ST_IDLE reloads PINS_IDLE, so address and lanes stay steady.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - CNT_W'(1);
    pins_nxt = pins_r;
    drive_nxt = drive_r;
    unique case (state_r)
      ST_POWER: begin
        if (pwr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        pins_nxt = PINS_IDLE;
        drive_nxt = 1'b0;
        if (req_valid_i && req_i.write) begin
          state_nxt = ST_WSET;
          pins_nxt.word_address = req_i.word_address;
          pins_nxt.lower_byte_lane_en_n = req_i.lane_keep_n[0];
          pins_nxt.upper_byte_lane_en_n = req_i.lane_keep_n[1];
          pins_nxt.output_enable_n = 1'b1;
          drive_nxt = 1'b1;
        end else if (req_valid_i) begin
          state_nxt = ST_RWAIT;
          cnt_nxt = READ_WAIT_N;
          pins_nxt.word_address = req_i.word_address;
          pins_nxt.lower_byte_lane_en_n = req_i.lane_keep_n[0];
          pins_nxt.upper_byte_lane_en_n = req_i.lane_keep_n[1];
          pins_nxt.chip_select_n = lanes_off(req_i.lane_keep_n);
          pins_nxt.output_enable_n = lanes_off(req_i.lane_keep_n);
          drive_nxt = 1'b0;
        end
      end
      ST_WSET: begin
        state_nxt = ST_WPULS;
        cnt_nxt = WPULSE_N - CNT_W'(1);
        pins_nxt.chip_select_n = 1'b0;
        pins_nxt.write_strobe_n = 1'b0;
      end
      ST_WPULS: begin
        if (cnt_done) begin
          state_nxt = ST_WEND;
          pins_nxt.write_strobe_n = 1'b1;
        end
      end
      ST_WEND: begin
        // bus released early
        // Letting go of the bus here keeps a following read off a driven bus.
        state_nxt = ST_IDLE;
        pins_nxt.chip_select_n = 1'b1;
        drive_nxt = 1'b0;
      end
      ST_RWAIT: begin
        if (cnt_done) begin
          state_nxt = ST_RCAP;
        end
      end
      ST_RCAP: begin
        state_nxt = ST_IDLE;
        pins_nxt = PINS_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        pins_nxt = PINS_IDLE;
        drive_nxt = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_POWER;
      cnt_r <= '0;
      pins_r <= PINS_IDLE;
      drive_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      drive_r <= drive_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_cnt_r <= PWR_W'(POWER_UP_CYCLES);
    end else if (!pwr_done) begin
      pwr_cnt_r <= pwr_cnt_r - PWR_W'(1);
    end
  end

  // Request latch; write data is held steady through the whole write.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_r <= '0;
    end else if (take_req) begin
      req_r <= req_i;
    end
  end

  // ---------------------------------------------------------------------------
  // User-side outputs
  // ---------------------------------------------------------------------------
  // unselected lanes read zero
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      rdata_valid_o <= (state_r == ST_RCAP);
      if (state_r == ST_RCAP) begin
        rdata_o[BYTE_W-1:0] <= req_r.lane_keep_n[0] ? '0 : rd_sync[BYTE_W-1:0];
        rdata_o[DATA_W-1:BYTE_W] <= req_r.lane_keep_n[1] ? '0 : rd_sync[DATA_W-1:BYTE_W];
      end
      req_ready_o <= (state_nxt == ST_IDLE) && !take_req;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  // lanes and drive
  assign word_address_o = pins_r.word_address;
  assign chip_select_n_o = pins_r.chip_select_n;
  assign write_strobe_n_o = pins_r.write_strobe_n;
  assign output_enable_n_o = pins_r.output_enable_n;
  assign lower_byte_lane_en_n_o = pins_r.lower_byte_lane_en_n;
  assign upper_byte_lane_en_n_o = pins_r.upper_byte_lane_en_n;
  assign shared_data_bus_o = req_r.wdata;
  assign shared_data_bus_oe_n_o = {DATA_W{~drive_r}};

endmodule

`default_nettype wire

// >>> tb/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory on the far side; slow_i stretches the read access.
module sram_model
  import sram_host_pkg::*;
(
  input wire logic slow_i,
  input wire sram_host_pkg::sram_pins_t pins_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] drv_o
);
  bit [15:0] mem [bit [ADDR_W-1:0]];
  logic [15:0] word;
  int upd = 0;
  wire wr_n = pins_i.chip_select_n | pins_i.write_strobe_n;
  wire rd = !pins_i.chip_select_n && !pins_i.output_enable_n && pins_i.write_strobe_n;
  always @(posedge wr_n) begin
    if ($time > 0) begin
      if (!pins_i.lower_byte_lane_en_n) mem[pins_i.word_address][7:0] = dq_i[7:0];
      if (!pins_i.upper_byte_lane_en_n) mem[pins_i.word_address][15:8] = dq_i[15:8];
      upd++;
    end
  end
  // lane drive; deselected means idle and floating.
  assign drv_o = {{8{rd && !pins_i.upper_byte_lane_en_n}},
                  {8{rd && !pins_i.lower_byte_lane_en_n}}};
  // old data held until access time.
  always @(pins_i.word_address, upd) begin
    word = mem.exists(pins_i.word_address) ? mem[pins_i.word_address] : 16'h0;
  end
  always @(word) dq_o <= #(slow_i ? 10 : 1) word;
endmodule
`default_nettype wire

// >>> tb/sram_host_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-order checks on the memory side of the controller.
module sram_host_ctrl_checker #(
  parameter int POWER_UP_CYCLES = 200
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic rdata_valid_o,
  input wire logic [17:0] word_address_o,
  input wire logic chip_select_n_o,
  input wire logic write_strobe_n_o,
  input wire logic output_enable_n_o,
  input wire logic lower_byte_lane_en_n_o,
  input wire logic upper_byte_lane_en_n_o,
  input wire logic [15:0] shared_data_bus_oe_n_o
);
  logic [15:0] up_r;
  wire wr = !chip_select_n_o && !write_strobe_n_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Cycles since reset release, saturating so it never wraps.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) up_r <= '0;
    else if (up_r != 16'hffff) up_r <= up_r + 16'h1;
  end
  AST_POWER_UP: assert property (!chip_select_n_o |-> up_r >= POWER_UP_CYCLES)
    else $error("select before power-up wait");
  AST_READ_STROBE: assert property (
    !chip_select_n_o && !output_enable_n_o |-> write_strobe_n_o)
    else $error("strobe low during read");
  AST_NO_CONTENTION: assert property (
    !output_enable_n_o |-> &shared_data_bus_oe_n_o)
    else $error("bus driven with output enable low");
  AST_BUS_RELEASED: assert property (
    $fell(output_enable_n_o) |-> &$past(shared_data_bus_oe_n_o))
    else $error("bus still driven the cycle before output enable fell");
  AST_WRITE_DATA: assert property (wr |-> shared_data_bus_oe_n_o == 16'h0)
    else $error("write without bus data");
  AST_WRITE_PULSE: assert property (
    $fell(write_strobe_n_o) |-> wr[*2] ##1 write_strobe_n_o && !chip_select_n_o)
    else $error("write pulse length");
  AST_END_BY_STROBE: assert property (
    $rose(chip_select_n_o) |-> $past(write_strobe_n_o))
    else $error("select rose before strobe");
  AST_ADDR_STABLE: assert property (
    wr ##1 wr |-> $stable(word_address_o) &&
    $stable({lower_byte_lane_en_n_o, upper_byte_lane_en_n_o}))
    else $error("address moved in write");
  AST_READ_HOLD: assert property (
    $fell(output_enable_n_o) |-> (!chip_select_n_o && !output_enable_n_o)[*5])
    else $error("read access too short");
  AST_READ_VALID: assert property (
    rdata_valid_o && !$past(chip_select_n_o) |-> !$past(output_enable_n_o, 4))
    else $error("data taken too early");
endmodule
bind sram_host_ctrl sram_host_ctrl_checker #(
  .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_chk (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .rdata_valid_o(rdata_valid_o),
  .word_address_o(word_address_o),
  .chip_select_n_o(chip_select_n_o),
  .write_strobe_n_o(write_strobe_n_o),
  .output_enable_n_o(output_enable_n_o),
  .lower_byte_lane_en_n_o(lower_byte_lane_en_n_o),
  .upper_byte_lane_en_n_o(upper_byte_lane_en_n_o),
  .shared_data_bus_oe_n_o(shared_data_bus_oe_n_o)
);
`default_nettype wire

// >>> tb/async_sram_256k_x16_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_256k_x16_tb;
  import sram_host_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic slow = 1'b0;
  sram_req_t req_i = '0;
  sram_pins_t pins;
  logic [17:0] pin_addr;
  logic pin_cs_n, pin_we_n, pin_oe_n, pin_lo_n, pin_up_n;
  logic req_ready_o, rdata_valid_o;
  logic [15:0] rdata_o, bus_o, bus_oe_n, bus_w, dq, drv;
  logic [15:0] float_r = 16'h5a5a;
  logic [15:0] exp_q [$];
  bit [15:0] shadow [bit [17:0]];
  int n_fail = 0;
  int tests_run = 0;
  // Clock, and a floating bus pattern that changes every cycle.
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) float_r <= ~float_r;
  assign bus_w = (dq & drv) | (bus_o & ~bus_oe_n & ~drv) | (float_r & bus_oe_n & ~drv);
  // Pins gathered into one carrier for the memory model.
  assign pins = {pin_cs_n, pin_we_n, pin_oe_n, pin_lo_n, pin_up_n, pin_addr};
  sram_host_ctrl #(
    .POWER_UP_CYCLES(4)
  ) u_dut (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .req_i(req_i),
    .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o),
    .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o),
    .word_address_o(pin_addr),
    .chip_select_n_o(pin_cs_n),
    .write_strobe_n_o(pin_we_n),
    .output_enable_n_o(pin_oe_n),
    .lower_byte_lane_en_n_o(pin_lo_n),
    .upper_byte_lane_en_n_o(pin_up_n),
    .shared_data_bus_o(bus_o),
    .shared_data_bus_oe_n_o(bus_oe_n),
    .shared_data_bus_i(bus_w)
  );
  sram_model u_mem (.slow_i(slow), .pins_i(pins), .dq_i(bus_w), .dq_o(dq), .drv_o(drv));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One request, held until taken; a read notes its expected word.
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [1:0] k,
                      input logic [15:0] d);
    logic [15:0] m;
    logic [15:0] old;
    m = {{8{~k[1]}}, {8{~k[0]}}};
    old = shadow.exists(a) ? shadow[a] : 16'h0;
    req_i = '{wr, a, k, d};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    if (wr) shadow[a] = (old & ~m) | (d & m);
    else exp_q.push_back(old & m);
    @(negedge sys_clk_i);
  endtask
  // Each read result is matched against the oldest note.
  always @(negedge sys_clk_i) begin
    if (rdata_valid_o === 1'b1) begin
      check(rdata_o, exp_q.size() ? exp_q.pop_front() : ~rdata_o);
    end
  end
  // Main sequence: boundaries, single lanes, random traffic, reset.
  initial begin
    void'($urandom(62635));
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    check({15'h0, req_ready_o}, 16'h0);
    xfer(1'b1, 18'h0, 2'b00, 16'ha55a);
    xfer(1'b1, 18'h3ffff, 2'b00, 16'h1234);
    xfer(1'b0, 18'h0, 2'b00, 16'h0);
    xfer(1'b0, 18'h3ffff, 2'b00, 16'h0);
    xfer(1'b1, 18'h155, 2'b10, 16'h00c3);
    xfer(1'b1, 18'h155, 2'b01, 16'h7e00);
    for (int k = 0; k < 4; k++) xfer(1'b0, 18'h155, k[1:0], 16'h0);
    slow = 1'b1;
    repeat (40) xfer(1'($urandom), 18'($urandom_range(7)), 2'($urandom), 16'($urandom));
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b0;
    @(negedge sys_clk_i);
    check({rdata_valid_o, req_ready_o, 14'h0}, 16'h0);
    nrst_i = 1'b1;
    xfer(1'b0, 18'h155, 2'b00, 16'h0);
    repeat (10) @(negedge sys_clk_i);
    check(16'(exp_q.size()), 16'h0);
    stop_test();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #25000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
